// [rtl/atx_pkg.sv]
// constants, types and timing for the aes3 tx boundary and mono block
// assumes one clock, the output master clock, for all users
package atx_pkg;

    localparam int unsigned DATA_W = 24;
    localparam int unsigned FIFO_DEPTH = 16;
    // output master clock cycles per sub-frame slot
    localparam int unsigned SUB_CYC = 32;
    localparam int unsigned HALF_SUB = SUB_CYC / 2;
    localparam int unsigned SLOT_W = $clog2(SUB_CYC);
    // frames in one channel status block
    localparam int unsigned BLK_FRAMES = 192;
    localparam int unsigned FRM_W = 8;
    // frames for which the boundary output stays high
    localparam int unsigned BND_HIGH_FRAMES = 16;
    // boundary input must be high for more than this many cycles
    localparam int unsigned BND_MIN_HIGH = 3;
    localparam int unsigned BND_CNT_W = 3;

    localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SUB_CYC - 1);
    localparam logic [SLOT_W-1:0] SLOT_HALF = SLOT_W'(HALF_SUB);
    localparam logic [FRM_W-1:0] FRM_LAST = FRM_W'(BLK_FRAMES - 1);
    localparam logic [FRM_W-1:0] FRM_BND_END = FRM_W'(BND_HIGH_FRAMES);
    localparam logic [BND_CNT_W-1:0] BND_CNT_HIT = BND_CNT_W'(BND_MIN_HIGH);

    typedef enum logic [1:0] {
        ATX_PRE_Z,
        ATX_PRE_X,
        ATX_PRE_Y
    } atx_pre_t;

    typedef enum logic {
        ATX_SRC_RX,
        ATX_SRC_SERIAL
    } atx_src_t;

    typedef enum logic {
        ATX_SUB_A,
        ATX_SUB_B
    } atx_sub_t;

    typedef struct packed {
        logic [DATA_W-1:0] left;
        logic [DATA_W-1:0] right;
    } atx_sample_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        atx_pre_t pre;
        logic cs;
        logic user;
    } atx_subframe_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic is_a;
    } atx_rx_sub_t;

endpackage

// [rtl/atx_fifo.sv]
// synchronous fifo with valid and ready on both sides
// assumes single clock, synchronous active-low reset
`timescale 1ns/1ps
module atx_fifo #(
    parameter int unsigned WIDTH = 48,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // fill side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int unsigned PW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic full_q;
    logic empty_q;
    logic push;
    logic pop;

    assign push = i_valid && !full_q;
    assign pop = i_ready && !empty_q;
    assign o_valid = !empty_q;
    assign o_data = mem_q[rd_q];
    assign cnt_d = cnt_q + (push ? CNT_ONE : '0) - (pop ? CNT_ONE : '0);

    always_ff @(posedge i_clk_sys)
    begin
        if (push)
        begin
            mem_q[wr_q] <= i_data;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
            o_ready <= 1'b1;
        end
        else
        begin
            wr_q <= push ? PW'(wr_q + 1'b1) : wr_q;
            rd_q <= pop ? PW'(rd_q + 1'b1) : rd_q;
            cnt_q <= cnt_d;
            full_q <= (cnt_d == CNT_FULL);
            // ready straight from a flop, same timing as the full flag
            o_ready <= (cnt_d != CNT_FULL);
            empty_q <= (cnt_d == '0);
        end
    end
endmodule // atx_fifo

// [rtl/atx_bnd_qual.sv]
// qualifies the block-boundary input: one pulse per long high
// assumes the pin is synchronous to the output master clock
`timescale 1ns/1ps
module atx_bnd_qual (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // pin and result
    input wire logic i_pin,
    output logic o_pulse
);
    logic [atx_pkg::BND_CNT_W-1:0] cnt_q;

    // count consecutive high cycles, saturating past the threshold
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            cnt_q <= '0;
        end
        else if (!i_pin)
        begin
            cnt_q <= '0;
        end
        else if (cnt_q <= atx_pkg::BND_CNT_HIT)
        begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // fires on the fourth high cycle only
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            o_pulse <= 1'b0;
        end
        else
        begin
            o_pulse <= i_pin && (cnt_q == atx_pkg::BND_CNT_HIT); // [R2] [R18]
        end
    end

    short_high_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_pulse |-> $past(i_pin, 1) && $past(i_pin, 2) && $past(i_pin, 3)
            && $past(i_pin, 4)) // [R18]
        else $error("boundary pulse after a short high");

    long_high_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !i_pin ##1 i_pin [*4] |=> o_pulse) // [R2]
        else $error("long boundary high gave no pulse");
endmodule // atx_bnd_qual

// [rtl/atx_core.sv]
// aes3 transmit framing, boundary pin, line drivers and mono routing
// assumes i_clk_sys is the output master clock; inputs synchronous to it
// Summary of operation
// [R1] boundary pin works as input or output
// [R2] input high over 3 cycles restarts frame, block
// [R3] output mode with rx source aligns frames
// [R4] output mode serial source aligns A to clock
// [R5] line outputs grounded: reset, no clock, request
// [R6] mute bit zeroes transmitted audio at once
// [R7] separate rx and tx mono select bits
// [R8] rx mono doubles sample rate and clock
// [R9] rx mono sends A, B as consecutive samples
// [R10] tx mono alternates one channel into A, B
// [R11] tx mono picks which status block is sent
// [R12] rx mono serial out: same left, right
// [R13] tx mono frame rate half input rate
// [R14] tx mono takes left or right positions
// [R15] word timing 50% duty, doubled in mono
// [R16] user bits from pin or internal storage
// [R17] transmitter clocked by output master clock
// [R18] boundary highs of 3 cycles ignored
`timescale 1ns/1ps
module atx_core (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // control bits
    input wire logic i_bnd_dir_out,
    input wire atx_pkg::atx_src_t i_tx_src,
    input wire logic i_tx_mono_select,
    input wire logic i_tx_mono_side_pick,
    input wire logic i_tx_mono_cs_pick,
    input wire logic i_rx_mono_select,
    input wire logic i_tx_mute,
    input wire logic i_line_force_gnd,
    input wire logic i_user_from_pin,
    input wire logic i_input_word_clock_polarity,
    // timing references
    input wire logic i_tx_clk_present,
    input wire logic i_rx_frame_start,
    input wire logic i_input_word_clock,
    // block boundary pin
    input wire logic i_tx_block_boundary,
    output logic o_tx_block_boundary,
    output logic o_tx_block_boundary_oe_n,
    // transmit sample stream
    input wire logic i_smp_valid,
    input wire atx_pkg::atx_sample_t i_smp,
    output logic o_smp_ready,
    // channel status and user bits
    input wire logic i_cs_a,
    input wire logic i_cs_b,
    input wire logic i_user_store,
    input wire logic i_user_pin,
    output logic [atx_pkg::FRM_W-1:0] o_cs_frame_idx,
    output logic o_virtual_word_clock,
    // sub-frames to the encoder
    output logic o_sub_valid,
    output atx_pkg::atx_subframe_t o_sub,
    // line drivers
    input wire logic i_biphase_bit,
    output logic o_line_out_pos,
    output logic o_line_out_neg,
    // received sub-frames in, samples out
    input wire logic i_rx_sub_valid,
    input wire atx_pkg::atx_rx_sub_t i_rx_sub,
    output logic o_rx_smp_valid,
    output atx_pkg::atx_sample_t o_rx_smp,
    output logic o_rx_rate_x2
);
    // fifo and boundary qualifier
    logic fifo_ready;
    logic fifo_valid;
    logic fifo_pop;
    atx_pkg::atx_sample_t fifo_data;
    logic bnd_pulse;

    // frame timing
    logic [atx_pkg::SLOT_W-1:0] slot_q;
    atx_pkg::atx_sub_t sub_q;
    logic [atx_pkg::FRM_W-1:0] frm_q;
    logic [atx_pkg::FRM_W-1:0] frm_next;
    logic wclk_q;
    logic wclk_now;
    logic wclk_lead;
    logic blk_restart;
    logic align;
    logic slot_end;
    logic start;
    atx_pkg::atx_sub_t sub_d;
    logic [atx_pkg::FRM_W-1:0] frm_d;

    // sample selection
    atx_pkg::atx_sample_t hold_q;
    atx_pkg::atx_sample_t cur;
    logic [atx_pkg::DATA_W-1:0] pick;
    logic mono_side_d;

    // receive pairing
    logic [atx_pkg::DATA_W-1:0] rx_a_q;
    logic rx_have_a_q;

    atx_fifo #(
        .WIDTH($bits(atx_pkg::atx_sample_t)),
        .DEPTH(atx_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_valid(i_smp_valid),
        .i_data(i_smp),
        .o_ready(fifo_ready),
        .o_valid(fifo_valid),
        .o_data(fifo_data),
        .i_ready(fifo_pop)
    );

    atx_bnd_qual u_bnd_qual (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_pin(i_tx_block_boundary),
        .o_pulse(bnd_pulse)
    );

    assign o_smp_ready = fifo_ready;

    // restart and alignment events
    assign wclk_now = i_input_word_clock ^ i_input_word_clock_polarity;
    assign wclk_lead = wclk_now && !wclk_q;
    assign blk_restart = !i_bnd_dir_out && bnd_pulse; // [R1] [R2] [R18]
    always_comb
    begin
        align = 1'b0;
        if (i_bnd_dir_out && i_tx_src == atx_pkg::ATX_SRC_RX)
        begin
            align = i_rx_frame_start; // [R3]
        end
        else if (i_bnd_dir_out)
        begin
            // in mono the word clock leads twice per frame; only B precedes A
            align = wclk_lead && (!i_tx_mono_select || sub_q == atx_pkg::ATX_SUB_B); // [R4]
        end
    end

    assign slot_end = (slot_q == atx_pkg::SLOT_LAST);
    assign start = blk_restart || align || slot_end;
    assign frm_next = (frm_q == atx_pkg::FRM_LAST) ? '0 : frm_q + 1'b1;

    always_comb
    begin
        sub_d = sub_q;
        frm_d = frm_q;
        if (blk_restart)
        begin
            sub_d = atx_pkg::ATX_SUB_A;
            frm_d = '0;
        end
        else if (align)
        begin
            sub_d = atx_pkg::ATX_SUB_A;
            frm_d = (sub_q == atx_pkg::ATX_SUB_B) ? frm_next : frm_q;
        end
        else if (slot_end && sub_q == atx_pkg::ATX_SUB_A)
        begin
            sub_d = atx_pkg::ATX_SUB_B;
        end
        else if (slot_end)
        begin
            sub_d = atx_pkg::ATX_SUB_A;
            frm_d = frm_next;
        end
    end

    // slot and frame counters run on the output master clock
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            slot_q <= '0;
            sub_q <= atx_pkg::ATX_SUB_A;
            frm_q <= '0;
            // follow the pin in reset: no false leading edge on release
            wclk_q <= wclk_now;
        end
        else
        begin
            slot_q <= start ? '0 : slot_q + 1'b1; // [R17]
            sub_q <= sub_d;
            frm_q <= frm_d;
            wclk_q <= wclk_now;
        end
    end

    // stereo pops one sample per frame, mono one per sub-frame
    assign fifo_pop = start && (i_tx_mono_select || sub_d == atx_pkg::ATX_SUB_A); // [R13]
    assign cur = fifo_valid ? fifo_data : hold_q;
    assign mono_side_d = i_tx_mono_side_pick;
    assign pick = mono_side_d ? cur.right : cur.left; // [R14]

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            hold_q <= '0;
        end
        else if (fifo_pop && fifo_valid)
        begin
            hold_q <= fifo_data;
        end
    end

    // sub-frame assembly
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            o_sub_valid <= 1'b0;
            o_sub <= '0;
        end
        else
        begin
            o_sub_valid <= start;
            if (start)
            begin
                if (i_tx_mute)
                begin
                    o_sub.data <= '0; // [R6]
                end
                else if (i_tx_mono_select)
                begin
                    o_sub.data <= pick; // [R10]
                end
                else if (sub_d == atx_pkg::ATX_SUB_A)
                begin
                    o_sub.data <= cur.left;
                end
                else
                begin
                    o_sub.data <= hold_q.right;
                end
                if (sub_d == atx_pkg::ATX_SUB_B)
                begin
                    o_sub.pre <= atx_pkg::ATX_PRE_Y;
                end
                else if (frm_d == '0)
                begin
                    o_sub.pre <= atx_pkg::ATX_PRE_Z;
                end
                else
                begin
                    o_sub.pre <= atx_pkg::ATX_PRE_X;
                end
                if (i_tx_mono_select)
                begin
                    o_sub.cs <= i_tx_mono_cs_pick ? i_cs_b : i_cs_a; // [R11]
                end
                else
                begin
                    o_sub.cs <= (sub_d == atx_pkg::ATX_SUB_B) ? i_cs_b : i_cs_a;
                end
                o_sub.user <= i_user_from_pin ? i_user_pin : i_user_store; // [R16]
            end
        end
    end

    // block index, boundary pin and word timing reference
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            o_cs_frame_idx <= '0;
            o_tx_block_boundary <= 1'b0;
            o_tx_block_boundary_oe_n <= 1'b1;
            o_virtual_word_clock <= 1'b0;
        end
        else
        begin
            o_cs_frame_idx <= frm_d;
            o_tx_block_boundary <= i_bnd_dir_out && (frm_d < atx_pkg::FRM_BND_END); // [R1]
            o_tx_block_boundary_oe_n <= !i_bnd_dir_out; // [R1]
            if (i_tx_mono_select)
            begin
                o_virtual_word_clock <= start || (slot_q < atx_pkg::SLOT_HALF - 1'b1); // [R15]
            end
            else
            begin
                o_virtual_word_clock <= (sub_d == atx_pkg::ATX_SUB_A); // [R15]
            end
        end
    end

    // line drivers forced low in reset, without clock, or on request
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            o_line_out_pos <= 1'b0;
            o_line_out_neg <= 1'b0;
        end
        else
        begin
            o_line_out_pos <= i_tx_clk_present && !i_line_force_gnd && i_biphase_bit; // [R5]
            o_line_out_neg <= i_tx_clk_present && !i_line_force_gnd && !i_biphase_bit; // [R5]
        end
    end

    // receive side: pairs A and B in stereo, one sample each in mono
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            rx_a_q <= '0;
            rx_have_a_q <= 1'b0;
            o_rx_smp_valid <= 1'b0;
            o_rx_smp <= '0;
            o_rx_rate_x2 <= 1'b0;
        end
        else
        begin
            o_rx_rate_x2 <= i_rx_mono_select; // [R7] [R8]
            o_rx_smp_valid <= 1'b0;
            if (i_rx_sub_valid && i_rx_mono_select)
            begin
                o_rx_smp.left <= i_rx_sub.data; // [R9] [R12]
                o_rx_smp.right <= i_rx_sub.data; // [R12]
                o_rx_smp_valid <= 1'b1;
                rx_have_a_q <= 1'b0;
            end
            else if (i_rx_sub_valid && i_rx_sub.is_a)
            begin
                rx_a_q <= i_rx_sub.data;
                rx_have_a_q <= 1'b1;
            end
            else if (i_rx_sub_valid && rx_have_a_q)
            begin
                o_rx_smp.left <= rx_a_q;
                o_rx_smp.right <= i_rx_sub.data;
                o_rx_smp_valid <= 1'b1;
                rx_have_a_q <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    bnd_restart_a: assert property (blk_restart |=> slot_q == '0
        && sub_q == atx_pkg::ATX_SUB_A && frm_q == '0) // [R2]
        else $error("boundary input did not restart block");
    rx_align_a: assert property (i_bnd_dir_out && i_tx_src == atx_pkg::ATX_SRC_RX
        && i_rx_frame_start |=> slot_q == '0 && sub_q == atx_pkg::ATX_SUB_A) // [R3]
        else $error("frame not aligned to receiver");
    wclk_align_a: assert property (i_bnd_dir_out && i_tx_src == atx_pkg::ATX_SRC_SERIAL
        && wclk_lead && !i_tx_mono_select |=> slot_q == '0
        && sub_q == atx_pkg::ATX_SUB_A) // [R4]
        else $error("A sub-frame not aligned to word clock");
    line_gnd_a: assert property (!i_tx_clk_present || i_line_force_gnd
        |=> !o_line_out_pos && !o_line_out_neg) // [R5]
        else $error("line driver not grounded");
    mute_data_a: assert property (start && i_tx_mute |=> o_sub_valid
        && o_sub.data == '0) // [R6]
        else $error("muted sub-frame carries audio");
    rx_rate_a: assert property (##1 o_rx_rate_x2 == $past(i_rx_mono_select)) // [R8]
        else $error("recovered rate flag wrong");
    rx_mono_a: assert property (i_rx_sub_valid && i_rx_mono_select
        |=> o_rx_smp_valid && o_rx_smp.left == $past(i_rx_sub.data)
        && o_rx_smp.right == o_rx_smp.left) // [R9]
        else $error("mono receive sample wrong");
    tx_mono_a: assert property (start && i_tx_mono_select && !i_tx_mute
        |=> o_sub.data == $past(pick)) // [R10]
        else $error("mono transmit data wrong");
    mono_cs_a: assert property (start && i_tx_mono_select
        |=> o_sub.cs == $past(i_tx_mono_cs_pick ? i_cs_b : i_cs_a)) // [R11]
        else $error("mono status block pick wrong");
    user_src_a: assert property (start && i_user_from_pin
        |=> o_sub.user == $past(i_user_pin)) // [R16]
        else $error("user bit not from pin");

    restart_c: cover property (blk_restart);
    mono_pair_c: cover property (start && i_tx_mono_select && fifo_valid
        ##[1:64] start && i_tx_mono_select && fifo_valid);
    rx_mono_c: cover property (i_rx_sub_valid && i_rx_mono_select);
    fifo_full_c: cover property (!fifo_ready);
endmodule // atx_core

// [verification/atx_line_sink.sv]
// receiving-end model: logs sub-frames and watches the line pair
// assumes every input is synchronous to i_clk_sys
`timescale 1ns/1ps
module atx_line_sink (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // what the block sends
    input wire logic i_sub_valid,
    input wire atx_pkg::atx_subframe_t i_sub,
    input wire logic i_line_out_pos,
    input wire logic i_line_out_neg,
    // line faults seen
    output logic [15:0] o_line_err
);
    atx_pkg::atx_subframe_t log_q[$];
    logic [15:0] err_q = 16'h0000;

    assign o_line_err = err_q;

    always @(posedge i_clk_sys)
    begin
        if (i_reset_n && i_sub_valid)
        begin
            log_q.push_back(i_sub);
        end
        // pair must be complementary or both grounded
        if (i_reset_n && {i_line_out_pos, i_line_out_neg} !== 2'b00
            && i_line_out_pos !== ~i_line_out_neg)
        begin
            err_q <= err_q + 16'h0001;
        end
    end
endmodule // atx_line_sink

// [verification/aes3_tx_boundary_and_mono_mode_tb.sv]
// bench: boundary pin, line drivers, stereo and mono routing
// assumes the core holds its own fifo; far end is the line sink model
`timescale 1ns/1ps
module aes3_tx_boundary_and_mono_mode_tb;
    logic clk = 0, rst_n = 0, dir_out = 0, mono = 0, side = 0, cs_pick = 0, rx_mono = 0;
    logic mute = 0, gnd = 0, u_sel = 0, pol = 0, clk_ok = 1, rx_fs = 0, wclk = 0;
    logic bnd_drv = 0, smp_v = 0, cs_a = 1, cs_b = 0, u_st = 0, u_pin = 1, bip = 0, rx_v = 0;
    atx_pkg::atx_src_t src = atx_pkg::ATX_SRC_RX;
    atx_pkg::atx_sample_t smp = '0;
    atx_pkg::atx_rx_sub_t rx_sub = '0;
    logic bnd_pin, bnd_o, bnd_oe_n, smp_rdy, vwc, sub_v, pos, neg, rx_sv, x2;
    logic [7:0] fidx;
    logic [15:0] line_err;
    atx_pkg::atx_subframe_t sub;
    atx_pkg::atx_sample_t rx_smp, s;
    int err_count = 0, checked = 0, n, k, got;
    logic [31:0] lfsr_q = 32'h5117cc86;
    logic [23:0] eq[$];
    logic [23:0] a, b;

    always #2 clk = ~clk;
    assign bnd_pin = bnd_oe_n ? bnd_drv : bnd_o;

    atx_core i_atx_core (.i_clk_sys(clk), .i_reset_n(rst_n), .i_bnd_dir_out(dir_out),
        .i_tx_src(src), .i_tx_mono_select(mono), .i_tx_mono_side_pick(side),
        .i_tx_mono_cs_pick(cs_pick), .i_rx_mono_select(rx_mono), .i_tx_mute(mute),
        .i_line_force_gnd(gnd), .i_user_from_pin(u_sel), .i_input_word_clock_polarity(pol),
        .i_tx_clk_present(clk_ok), .i_rx_frame_start(rx_fs), .i_input_word_clock(wclk),
        .i_tx_block_boundary(bnd_pin), .o_tx_block_boundary(bnd_o),
        .o_tx_block_boundary_oe_n(bnd_oe_n), .i_smp_valid(smp_v), .i_smp(smp),
        .o_smp_ready(smp_rdy), .i_cs_a(cs_a), .i_cs_b(cs_b), .i_user_store(u_st),
        .i_user_pin(u_pin), .o_cs_frame_idx(fidx), .o_virtual_word_clock(vwc),
        .o_sub_valid(sub_v), .o_sub(sub), .i_biphase_bit(bip), .o_line_out_pos(pos),
        .o_line_out_neg(neg), .i_rx_sub_valid(rx_v), .i_rx_sub(rx_sub),
        .o_rx_smp_valid(rx_sv), .o_rx_smp(rx_smp), .o_rx_rate_x2(x2));

    atx_line_sink i_atx_line_sink (.i_clk_sys(clk), .i_reset_n(rst_n), .i_sub_valid(sub_v),
        .i_sub(sub), .i_line_out_pos(pos), .i_line_out_neg(neg), .o_line_err(line_err));

    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic exp_cs(input logic is_b);
        return (mono ? cs_pick : is_b) ? cs_b : cs_a;
    endfunction

    task automatic check(input logic [48:0] seen, input logic [48:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    task automatic print_verdict;
        $display("mismatches %0d of %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic tick(input int c);
        repeat (c) @(negedge clk);
    endtask

    task automatic wait_sub(input int lim, output int c);
        c = 0;
        do
        begin
            tick(1);
            c++;
        end
        while (sub_v !== 1'b1 && c < lim);
        check(sub_v, 1, "no sub-frame start");
    endtask

    task automatic rnd24(output logic [23:0] v);
        lfsr_q = lfsr_step(lfsr_q);
        v = lfsr_q[23:0];
    endtask

    // push up to c samples while accepted, then match the logged stream
    task automatic stream(input int c);
        int i;
        i_atx_line_sink.log_q.delete();
        eq.delete();
        got = 0;
        while (smp_rdy === 1'b1 && got < c)
        begin
            rnd24(smp.left);
            rnd24(smp.right);
            smp_v = 1'b1;
            if (mono)
                eq.push_back(side ? smp.right : smp.left);
            else
            begin
                eq.push_back(smp.left);
                eq.push_back(smp.right);
            end
            got++;
            tick(1);
        end
        smp_v = 1'b0;
        i = 0;
        while (i_atx_line_sink.log_q.size() < eq.size() + 4 && i < 8000)
        begin
            tick(1);
            i++;
        end
        i = 0;
        while (i < 3 && i_atx_line_sink.log_q[i].data !== eq[0])
            i++;
        for (int j = 0; j < eq.size(); j++)
        begin
            check(i_atx_line_sink.log_q[i+j].data, eq[j], "sub-frame data");
            check(i_atx_line_sink.log_q[i+j].cs,
                exp_cs(i_atx_line_sink.log_q[i+j].pre == atx_pkg::ATX_PRE_Y), "cs");
            if (!mono)
                check(i_atx_line_sink.log_q[i+j].pre == atx_pkg::ATX_PRE_Y,
                    j % 2, "pre");
        end
    endtask

    task automatic rx_put(input logic [23:0] d, input logic is_a);
        rx_sub = '{data: d, is_a: is_a};
        rx_v = 1'b1;
        tick(1);
    endtask

    task automatic rx_get(input logic [47:0] exp, input logic want);
        int c;
        c = 0;
        while (rx_sv !== 1'b1 && c < 3)
        begin
            tick(1);
            c++;
        end
        check({rx_sv, rx_sv ? rx_smp : 48'h0}, {want, want ? exp : 48'h0}, "rx");
        tick(3);
    endtask

    initial
    begin
        tick(8);
        check({pos, neg, sub_v, bnd_oe_n, smp_rdy}, 5'b00011, "reset outputs");
        rst_n = 1'b1;
        for (int m = 0; m < 3; m++)
        begin
            gnd = (m == 1);
            clk_ok = (m != 2);
            repeat (6)
            begin
                lfsr_q = lfsr_step(lfsr_q);
                bip = lfsr_q[0];
                tick(1);
                check({pos, neg}, (m == 0) ? {bip, ~bip} : 2'b00, "line drivers");
            end
        end
        gnd = 0;
        clk_ok = 1;
        stream(20);
        check(got >= 16 && got <= 17, 1, "fifo fill count");
        check(smp_rdy, 1, "fifo not drained");
        mono = 1;
        cs_pick = 1;
        for (int p = 0; p < 2; p++)
        begin
            side = p[0];
            stream(6);
        end
        cs_pick = 0;
        stream(4);
        wait_sub(80, n);
        tick(8);
        check(vwc, 1, "mono word timing high");
        tick(16);
        check(vwc, 0, "mono word timing low");
        mono = 0;
        for (int c = 0; c < 4; c++)
        begin
            mute = c[0];
            u_sel = c[1];
            wait_sub(80, n);
            wait_sub(40, n);
            if (mute)
                check(sub.data, 0, "muted data");
            check(sub.user, u_sel, "user bit source");
        end
        mute = 0;
        for (int l = 3; l < 6; l++)
        begin
            wait_sub(80, n);
            tick(4);
            bnd_drv = 1;
            tick(l);
            bnd_drv = 0;
            // a long high may already have restarted by the time it ends
            if (sub_v === 1'b1)
                n = 0;
            else
                wait_sub(40, n);
            check(4 + l + n, (l == 3) ? 32 : 9, "restart timing");
            if (l > 3)
                check({sub.pre, fidx}, {atx_pkg::ATX_PRE_Z, 8'h00}, "block restart");
        end
        tick(8);
        check(vwc, 1, "word timing during A");
        tick(atx_pkg::SUB_CYC);
        check(vwc, 0, "word timing during B");
        dir_out = 1;
        tick(2);
        check(bnd_oe_n, 0, "pin not driven");
        k = 0;
        do
        begin
            wait_sub(80, n);
            k++;
        end
        while (sub.pre !== atx_pkg::ATX_PRE_Z && k < 400);
        tick(4);
        check(bnd_pin, 1, "boundary high at block start");
        tick(atx_pkg::BND_HIGH_FRAMES * 2 * atx_pkg::SUB_CYC + 6);
        check(bnd_pin, 0, "boundary low later");
        wait_sub(80, n);
        tick(10);
        rx_fs = 1;
        tick(1);
        rx_fs = 0;
        check(sub_v, 1, "rx frame align start");
        check(sub.pre == atx_pkg::ATX_PRE_Y, 0, "rx frame align");
        src = atx_pkg::ATX_SRC_SERIAL;
        for (int p = 0; p < 2; p++)
        begin
            pol = p[0];
            wclk = p[0];
            wait_sub(80, n);
            tick(10);
            wclk = ~p[0];
            wait_sub(6, n);
            check(n <= 4 && sub.pre !== atx_pkg::ATX_PRE_Y, 1, "word clock align");
        end
        dir_out = 0;
        src = atx_pkg::ATX_SRC_RX;
        tick(2);
        check(bnd_oe_n, 1, "pin released");
        rnd24(a);
        rnd24(b);
        check(x2, 0, "stereo rate");
        rx_put(a, 1);
        rx_put(b, 0);
        rx_v = 0;
        rx_get({a, b}, 1);
        rx_put(a, 0);
        rx_v = 0;
        rx_get(48'h0, 0);
        rx_mono = 1;
        tick(2);
        check(x2, 1, "mono rate doubled");
        rx_put(a, 1);
        rx_v = 0;
        rx_get({a, a}, 1);
        rx_put(b, 0);
        rx_v = 0;
        rx_get({b, b}, 1);
        check(line_err, 0, "line pair faults");
        print_verdict;
    end

    initial
    begin
        #200000;
        err_count++;
        print_verdict;
    end
endmodule // aes3_tx_boundary_and_mono_mode_tb
